/* File: include/crf_pkg.sv */
// Package for the CPU register file and flag word
`default_nettype none
package crf_pkg;
  localparam int GPR_COUNT  = 8;
  localparam int GPR_W      = 32;
  localparam int GPR_IDX_W  = 3;
  localparam int PC_W       = 24;
  localparam int FLAG_W     = 8;
  localparam logic [GPR_IDX_W-1:0] STACK_GPR_IDX = 3'h7;
  // Flag word bit positions
  localparam int FLG_IMASK = 7;
  localparam int FLG_AUX   = 6;
  localparam int FLG_HALF  = 5;
  localparam int FLG_USER  = 4;
  localparam int FLG_NEG   = 3;
  localparam int FLG_ZERO  = 2;
  localparam int FLG_OVF   = 1;
  localparam int FLG_CARRY = 0;
  // Half-carry tap bits per operand size
  localparam int HC_BYTE_BIT = 3;
  localparam int HC_WORD_BIT = 11;
  localparam int HC_LONG_BIT = 27;
  localparam logic [FLAG_W-1:0] FLAG_RST = 8'h80;
  localparam logic [PC_W-1:0]   PC_RST   = 24'h000000;
  localparam logic [GPR_W-1:0]  GPR_RST  = 32'h00000000;

  // Register view selector
  typedef enum logic [2:0] {
    VIEW_LONG, VIEW_EXT, VIEW_LOW, VIEW_UBYTE, VIEW_LBYTE
  } crf_view_t;
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} crf_size_t;
  // Flag update operation class
  typedef enum logic [3:0] {
    FOP_NONE, FOP_ADD, FOP_SUB, FOP_LOGIC, FOP_SHIFT, FOP_BITACC,
    FOP_LOAD, FOP_AND, FOP_OR, FOP_XOR, FOP_DAA, FOP_DAS
  } crf_fop_t;

  typedef struct packed {
    logic                 we;
    logic [GPR_IDX_W-1:0] idx;
    crf_view_t            view;
    logic [GPR_W-1:0]     data;
  } crf_gpr_wr_t;

  typedef struct packed {
    crf_fop_t         op;
    crf_size_t        size;
    logic [GPR_W-1:0] a;
    logic [GPR_W-1:0] b;
    logic             use_carry;
    logic [GPR_W-1:0] res;
    logic             shift_out;
    logic             bit_val;
    logic [FLAG_W-1:0] imm;
  } crf_flag_req_t;

  typedef struct packed {
    logic [GPR_COUNT-1:0][GPR_W-1:0] gpr;
    logic [PC_W-1:0]                 pc;
    logic [FLAG_W-1:0]               flags;
  } crf_state_t;
endpackage
`default_nettype wire

/* File: logic/crf_core.sv */
// Register file, program counter and flag word of the processor core
`timescale 1ns/1ps
`default_nettype none

// Contract
// (RULE1) Eight alike 32-bit general registers, readable as 32, 16 or 8 bits.
// (RULE2) Each register splits into extended and lower 16-bit halves.
// (RULE3) Lower half splits into upper byte and low byte.
// (RULE4) Eighth register doubles as stack pointer for exceptions and calls.
// (RULE5) 24-bit program counter; bit 0 reads as zero on fetch.
// (RULE6) Flag bit 7 masks all interrupts except the unmaskable one.
// (RULE7) Interrupt mask bit set at start of every exception sequence.
// (RULE8) Flag bit 6 read/write by flag ops, usable as extra mask.
// (RULE9) Half-carry from bit 3, 11 or 27 on add, subtract, compare, negate.
// (RULE10) Flag bit 4 is a user bit written by flag-word operations.
// (RULE11) Negative flag takes the result's sign bit.
// (RULE12) Zero flag set for zero result, cleared otherwise; add and subtract with carry keep the old Z on a zero result.
// (RULE13) Overflow flag set on arithmetic overflow, cleared otherwise.
// (RULE14) Carry holds add carry, subtract borrow, shifted bit, bit accumulator.
// (RULE15) Some ops leave flags; N, Z, V, C feed conditional branches.
// (RULE16) Reset loads PC from vector and sets the mask bit only.
// (RULE17) Software loads the stack pointer first after reset.
// (RULE18) Odd word or longword addresses silently drop address bit 0.
// (RULE19) Single-bit operations select bit 0 to 7 of a byte.
// (RULE20) Decimal adjust treats a byte as two packed BCD digits.
// (RULE21) Software uses word or longword size for stack accesses.
// (RULE22) Narrow writes keep the other bits of the 32-bit register.
module crf_core
  import crf_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire logic                  i_sys_rst,
  // Reset vector fetched by the exception sequencer
  input  wire logic                  i_vec_load,
  input  wire logic [PC_W-1:0]       i_vec_pc,
  input  wire logic                  i_exc_start,
  input  wire logic                  i_pc_we,
  input  wire logic [PC_W-1:0]       i_pc_d,
  input  wire crf_gpr_wr_t           i_gpr_wr,
  input  wire logic                  i_sp_we,
  input  wire logic [GPR_W-1:0]      i_sp_d,
  input  wire logic [GPR_IDX_W-1:0]  i_rd_idx,
  input  wire crf_view_t             i_rd_view,
  input  wire crf_flag_req_t         i_flag_req,
  input  wire logic [2:0]            i_bit_sel,
  input  wire logic [7:0]            i_bit_byte,
  input  wire logic [PC_W-1:0]       i_mem_addr,
  input  wire crf_size_t             i_mem_size,
  input  wire logic                  i_irq_req,
  input  wire logic                  i_unmaskable_irq,
  output logic [GPR_W-1:0]           o_rd_data,
  output logic [GPR_W-1:0]           o_sp,
  output logic [PC_W-1:0]            o_pc,
  output logic [PC_W-1:0]            o_fetch_addr,
  output logic [PC_W-1:0]            o_mem_addr,
  output logic [FLAG_W-1:0]          o_flags,
  output logic [3:0]                 o_branch_flags,
  output logic                       o_aux_mask,
  output logic                       o_irq_take,
  output logic                       o_sel_bit,
  output logic [7:0]                 o_bcd_adj
);

  crf_state_t s_q;
  crf_state_t s_d;

  // Extract a view of a register
  function automatic logic [GPR_W-1:0] view_rd(input logic [GPR_W-1:0] r,
                                               input crf_view_t v);
    logic [GPR_W-1:0] o;
    o = r;
    case (v)
      VIEW_LONG:  o = r;                       // RULE1
      VIEW_EXT:   o = {16'h0000, r[31:16]};    // RULE2
      VIEW_LOW:   o = {16'h0000, r[15:0]};     // RULE2
      VIEW_UBYTE: o = {24'h000000, r[15:8]};   // RULE3
      VIEW_LBYTE: o = {24'h000000, r[7:0]};    // RULE3
      default:    o = r;
    endcase
    return o;
  endfunction

  // Merge a narrow write into the full register
  function automatic logic [GPR_W-1:0] view_wr(input logic [GPR_W-1:0] r,
                                               input crf_view_t v,
                                               input logic [GPR_W-1:0] d);
    logic [GPR_W-1:0] o;
    o = r;
    case (v)
      VIEW_LONG:  o = d;
      VIEW_EXT:   o = {d[15:0], r[15:0]};           // RULE22
      VIEW_LOW:   o = {r[31:16], d[15:0]};          // RULE22
      VIEW_UBYTE: o = {r[31:16], d[7:0], r[7:0]};   // RULE22
      VIEW_LBYTE: o = {r[31:8], d[7:0]};            // RULE22
      default:    o = r;
    endcase
    return o;
  endfunction

  // Sign bit position per size
  function automatic logic msb_of(input logic [GPR_W-1:0] v, input crf_size_t sz);
    logic m;
    m = v[31];
    case (sz)
      SZ_BYTE: m = v[7];
      SZ_WORD: m = v[15];
      default: m = v[31];
    endcase
    return m;
  endfunction

  function automatic logic is_zero(input logic [GPR_W-1:0] v, input crf_size_t sz);
    logic z;
    z = (v == 32'h00000000);
    case (sz)
      SZ_BYTE: z = (v[7:0] == 8'h00);
      SZ_WORD: z = (v[15:0] == 16'h0000);
      default: z = (v == 32'h00000000);
    endcase
    return z;
  endfunction

  logic [32:0] add_full;
  logic [32:0] sub_full;
  logic [GPR_W-1:0] mask_a;
  logic [GPR_W-1:0] mask_b;
  logic        cin;
  logic        hc_add;
  logic        hc_sub;
  logic        cy_add;
  logic        cy_sub;
  logic        ov_add;
  logic        ov_sub;
  logic [FLAG_W-1:0] f;

  // Half-carry and carry taps for the selected size
  always_comb begin
    mask_a = i_flag_req.a;
    mask_b = i_flag_req.b;
    cin    = i_flag_req.use_carry & s_q.flags[FLG_CARRY];
    add_full = {1'b0, mask_a} + {1'b0, mask_b} + {32'h00000000, cin};
    sub_full = {1'b0, mask_a} - {1'b0, mask_b} - {32'h00000000, cin};
    hc_add = 1'b0;
    hc_sub = 1'b0;
    cy_add = add_full[32];
    cy_sub = sub_full[32];
    case (i_flag_req.size)
      SZ_BYTE: begin
        hc_add = (({1'b0, mask_a[3:0]} + {1'b0, mask_b[3:0]} + {4'h0, cin}) > 5'h0f); // RULE9
        hc_sub = ({1'b0, mask_a[3:0]} < ({1'b0, mask_b[3:0]} + {4'h0, cin}));          // RULE9
        cy_add = ({1'b0, mask_a[7:0]} + {1'b0, mask_b[7:0]} + {8'h00, cin}) > 9'h0ff;
        cy_sub = {1'b0, mask_a[7:0]} < ({1'b0, mask_b[7:0]} + {8'h00, cin});
      end
      SZ_WORD: begin
        hc_add = ({1'b0, mask_a[HC_WORD_BIT:0]} + {1'b0, mask_b[HC_WORD_BIT:0]}
                  + {12'h000, cin}) > 13'h0fff;                                        // RULE9
        hc_sub = {1'b0, mask_a[HC_WORD_BIT:0]}
                 < ({1'b0, mask_b[HC_WORD_BIT:0]} + {12'h000, cin});                   // RULE9
        cy_add = ({1'b0, mask_a[15:0]} + {1'b0, mask_b[15:0]} + {16'h0000, cin})
                 > 17'h0ffff;
        cy_sub = {1'b0, mask_a[15:0]} < ({1'b0, mask_b[15:0]} + {16'h0000, cin});
      end
      default: begin
        hc_add = ({1'b0, mask_a[HC_LONG_BIT:0]} + {1'b0, mask_b[HC_LONG_BIT:0]}
                  + {28'h0000000, cin}) > 29'h0fffffff;                                // RULE9
        hc_sub = {1'b0, mask_a[HC_LONG_BIT:0]}
                 < ({1'b0, mask_b[HC_LONG_BIT:0]} + {28'h0000000, cin});               // RULE9
      end
    endcase
    // Signed overflow from operand and result signs
    ov_add = (msb_of(mask_a, i_flag_req.size) == msb_of(mask_b, i_flag_req.size))
           & (msb_of(i_flag_req.res, i_flag_req.size) != msb_of(mask_a, i_flag_req.size));
    ov_sub = (msb_of(mask_a, i_flag_req.size) != msb_of(mask_b, i_flag_req.size))
           & (msb_of(i_flag_req.res, i_flag_req.size) != msb_of(mask_a, i_flag_req.size));
  end

  // Flag word next value
  always_comb begin
    f = s_q.flags;
    case (i_flag_req.op)
      FOP_NONE: f = s_q.flags;                                           // RULE15
      FOP_ADD: begin
        f[FLG_HALF]  = hc_add;
        f[FLG_NEG]   = msb_of(i_flag_req.res, i_flag_req.size);          // RULE11
        // Extended forms only keep Z clear, never set it, for multi-precision chains
        f[FLG_ZERO]  = is_zero(i_flag_req.res, i_flag_req.size)
                       & (~i_flag_req.use_carry | s_q.flags[FLG_ZERO]);  // RULE12
        f[FLG_OVF]   = ov_add;                                           // RULE13
        f[FLG_CARRY] = cy_add;                                           // RULE14
      end
      FOP_SUB: begin
        f[FLG_HALF]  = hc_sub;
        f[FLG_NEG]   = msb_of(i_flag_req.res, i_flag_req.size);          // RULE11
        f[FLG_ZERO]  = is_zero(i_flag_req.res, i_flag_req.size)
                       & (~i_flag_req.use_carry | s_q.flags[FLG_ZERO]);  // RULE12
        f[FLG_OVF]   = ov_sub;                                           // RULE13
        f[FLG_CARRY] = cy_sub;                                           // RULE14
      end
      FOP_LOGIC: begin
        f[FLG_NEG]  = msb_of(i_flag_req.res, i_flag_req.size);           // RULE11
        f[FLG_ZERO] = is_zero(i_flag_req.res, i_flag_req.size);          // RULE12
        f[FLG_OVF]  = 1'b0;                                              // RULE13
      end
      FOP_SHIFT: begin
        f[FLG_NEG]   = msb_of(i_flag_req.res, i_flag_req.size);          // RULE11
        f[FLG_ZERO]  = is_zero(i_flag_req.res, i_flag_req.size);         // RULE12
        f[FLG_OVF]   = 1'b0;
        f[FLG_CARRY] = i_flag_req.shift_out;                             // RULE14
      end
      FOP_BITACC: f[FLG_CARRY] = i_flag_req.bit_val;                     // RULE14
      FOP_LOAD:   f = i_flag_req.imm;                                    // RULE8 RULE10
      FOP_AND:    f = s_q.flags & i_flag_req.imm;                        // RULE8 RULE10
      FOP_OR:     f = s_q.flags | i_flag_req.imm;                        // RULE8 RULE10
      FOP_XOR:    f = s_q.flags ^ i_flag_req.imm;                        // RULE8 RULE10
      FOP_DAA, FOP_DAS: begin
        f[FLG_NEG]   = i_flag_req.res[7];
        f[FLG_ZERO]  = (i_flag_req.res[7:0] == 8'h00);
        f[FLG_CARRY] = s_q.flags[FLG_CARRY] | (i_flag_req.op == FOP_DAA && cy_add);
      end
      default: f = s_q.flags;
    endcase
    // Exception entry wins over any flag op in the same cycle
    if (i_exc_start) begin
      f[FLG_IMASK] = 1'b1;                                               // RULE7
    end
  end

  // Decimal adjust on two packed BCD digits of the low byte
  always_comb begin
    logic [7:0] v;
    logic [7:0] adj;
    v   = i_flag_req.a[7:0];
    adj = 8'h00;
    if (i_flag_req.op == FOP_DAA) begin
      if (s_q.flags[FLG_HALF] || v[3:0] > 4'h9) adj[3:0] = 4'h6;        // RULE20
      if (s_q.flags[FLG_CARRY] || v > 8'h99) adj[7:4] = 4'h6;           // RULE20
      o_bcd_adj = v + adj;
    end else if (i_flag_req.op == FOP_DAS) begin
      if (s_q.flags[FLG_HALF]) adj[3:0] = 4'h6;                          // RULE20
      if (s_q.flags[FLG_CARRY]) adj[7:4] = 4'h6;                         // RULE20
      o_bcd_adj = v - adj;
    end else begin
      o_bcd_adj = v;
    end
  end

  // Register state next value
  always_comb begin
    s_d       = s_q;
    s_d.flags = f;
    if (i_gpr_wr.we) begin
      s_d.gpr[i_gpr_wr.idx] = view_wr(s_q.gpr[i_gpr_wr.idx], i_gpr_wr.view,
                                      i_gpr_wr.data);                    // RULE1
    end
    // Implicit stack pointer update overrides a same-cycle ordinary write
    if (i_sp_we) begin
      s_d.gpr[STACK_GPR_IDX] = i_sp_d;                                   // RULE4
    end
    if (i_pc_we) begin
      s_d.pc = i_pc_d;
    end
    if (i_vec_load) begin
      s_d.pc = i_vec_pc;                                                 // RULE16
    end
  end

  // Only PC and the mask bit have a defined reset value; others reset
  // to zero here purely to keep simulation free of unknowns
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_q.gpr   <= {GPR_COUNT{GPR_RST}};
      s_q.pc    <= PC_RST;
      s_q.flags <= FLAG_RST;                                             // RULE16
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    o_rd_data      = view_rd(s_q.gpr[i_rd_idx], i_rd_view);              // RULE1
    o_sp           = s_q.gpr[STACK_GPR_IDX];                             // RULE4
    o_pc           = s_q.pc;
    o_fetch_addr   = {s_q.pc[PC_W-1:1], 1'b0};                           // RULE5
    o_mem_addr     = (i_mem_size == SZ_BYTE) ? i_mem_addr
                   : {i_mem_addr[PC_W-1:1], 1'b0};                       // RULE18
    o_flags        = s_q.flags;
    o_branch_flags = {s_q.flags[FLG_NEG], s_q.flags[FLG_ZERO],
                      s_q.flags[FLG_OVF], s_q.flags[FLG_CARRY]};         // RULE15
    o_aux_mask     = s_q.flags[FLG_AUX];                                 // RULE8
    o_irq_take     = i_unmaskable_irq
                   | (i_irq_req & ~s_q.flags[FLG_IMASK]);                // RULE6
    o_sel_bit      = i_bit_byte[i_bit_sel];                              // RULE19
  end

endmodule
`default_nettype wire

/* File: sim/crf_core_asserts.sv */
// Concurrent checks on the register file ports
`timescale 1ns/1ps
`default_nettype none
module crf_core_asserts
  import crf_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_vec_load,
  input  wire logic [PC_W-1:0]   i_vec_pc,
  input  wire logic              i_exc_start,
  input  wire crf_flag_req_t     i_flag_req,
  input  wire logic [2:0]        i_bit_sel,
  input  wire logic [7:0]        i_bit_byte,
  input  wire logic [PC_W-1:0]   i_mem_addr,
  input  wire crf_size_t         i_mem_size,
  input  wire logic              i_irq_req,
  input  wire logic              i_unmaskable_irq,
  input  wire logic [PC_W-1:0]   o_pc,
  input  wire logic [PC_W-1:0]   o_fetch_addr,
  input  wire logic [PC_W-1:0]   o_mem_addr,
  input  wire logic [FLAG_W-1:0] o_flags,
  input  wire logic [3:0]        o_branch_flags,
  input  wire logic              o_aux_mask,
  input  wire logic              o_irq_take,
  input  wire logic              o_sel_bit
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_exc; i_exc_start; endsequence
  sequence s_vec; i_vec_load; endsequence
  // Exception entry also overrides flag ops, so only a quiet cycle must hold
  sequence s_idle; i_flag_req.op == FOP_NONE && !i_exc_start; endsequence
  a_fetch_even: assert property (o_fetch_addr == {o_pc[PC_W-1:1], 1'h0})
    else $error("fetch address bit 0 not cleared");
  a_mem_align: assert property (i_mem_size != SZ_BYTE |->
    o_mem_addr == {i_mem_addr[PC_W-1:1], 1'h0}) else $error("wide access not aligned");
  a_irq_gate: assert property (o_irq_take ==
    (i_unmaskable_irq | (i_irq_req & ~o_flags[FLG_IMASK]))) else $error("irq gating wrong");
  a_exc_mask: assert property (s_exc |=> o_flags[FLG_IMASK])
    else $error("mask bit not set on exception");
  a_vec_load: assert property (s_vec |=> o_pc == $past(i_vec_pc))
    else $error("pc not loaded from vector");
  a_branch_flags: assert property (o_branch_flags == o_flags[3:0])
    else $error("branch flags differ from flag word");
  a_aux_bit: assert property (o_aux_mask == o_flags[FLG_AUX])
    else $error("aux mask differs from flag bit");
  a_bit_pick: assert property (o_sel_bit == i_bit_byte[i_bit_sel])
    else $error("selected bit wrong");
  a_flags_hold: assert property (s_idle |=> $stable(o_flags))
    else $error("flags changed without an op");
endmodule
bind crf_core crf_core_asserts crf_core_asserts_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_vec_load(i_vec_load), .i_vec_pc(i_vec_pc), .i_exc_start(i_exc_start),
  .i_flag_req(i_flag_req), .i_bit_sel(i_bit_sel), .i_bit_byte(i_bit_byte),
  .i_mem_addr(i_mem_addr), .i_mem_size(i_mem_size), .i_irq_req(i_irq_req),
  .i_unmaskable_irq(i_unmaskable_irq), .o_pc(o_pc), .o_fetch_addr(o_fetch_addr),
  .o_mem_addr(o_mem_addr), .o_flags(o_flags), .o_branch_flags(o_branch_flags),
  .o_aux_mask(o_aux_mask), .o_irq_take(o_irq_take), .o_sel_bit(o_sel_bit));
`default_nettype wire

/* File: sim/crf_core_test.sv */
// Self-checking bench for the register file and flag word
`timescale 1ns/1ps
`default_nettype none
module crf_core_test
  import crf_pkg::*;
();
  typedef struct packed {
    crf_fop_t    op;
    crf_size_t   sz;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] res;
    logic [7:0]  imm;
    logic [7:0]  exp;
    logic [7:0]  msk;
  } crf_row_t;
  // Flag ops in order; the flag-word ops chain so the word ends at zero
  localparam crf_row_t ROWS [15] = '{
    '{FOP_ADD, SZ_BYTE, 32'h0f, 32'h01, 32'h10, 8'h00, 8'h20, 8'h2f},
    '{FOP_ADD, SZ_BYTE, 32'hff, 32'h01, 32'h00, 8'h00, 8'h25, 8'h2f},
    '{FOP_ADD, SZ_BYTE, 32'h7f, 32'h01, 32'h80, 8'h00, 8'h2a, 8'h2f},
    '{FOP_ADD, SZ_WORD, 32'h0800, 32'h0800, 32'h1000, 8'h00, 8'h20, 8'h2f},
    '{FOP_ADD, SZ_LONG, 32'h08000000, 32'h08000000, 32'h10000000, 8'h00, 8'h20, 8'h2f},
    '{FOP_SUB, SZ_BYTE, 32'h00, 32'h01, 32'hff, 8'h00, 8'h29, 8'h2f},
    '{FOP_SUB, SZ_WORD, 32'h8000, 32'h0001, 32'h7fff, 8'h00, 8'h22, 8'h2f},
    '{FOP_LOGIC, SZ_BYTE, 32'h00, 32'h00, 32'h00, 8'h00, 8'h04, 8'h0e},
    '{FOP_SHIFT, SZ_BYTE, 32'h00, 32'h00, 32'h80, 8'h01, 8'h09, 8'h0f},
    '{FOP_BITACC, SZ_BYTE, 32'h00, 32'h00, 32'h00, 8'h01, 8'h01, 8'h01},
    '{FOP_LOAD, SZ_BYTE, 32'h00, 32'h00, 32'h00, 8'h5a, 8'h5a, 8'hff},
    '{FOP_AND, SZ_BYTE, 32'h00, 32'h00, 32'h00, 8'hf0, 8'h50, 8'hff},
    '{FOP_OR, SZ_BYTE, 32'h00, 32'h00, 32'h00, 8'h05, 8'h55, 8'hff},
    '{FOP_XOR, SZ_BYTE, 32'h00, 32'h00, 32'h00, 8'h55, 8'h00, 8'hff},
    '{FOP_NONE, SZ_BYTE, 32'h00, 32'h00, 32'h00, 8'hff, 8'h00, 8'hff}};
  localparam crf_view_t   NV [4] = '{VIEW_EXT, VIEW_LOW, VIEW_UBYTE, VIEW_LBYTE};
  localparam logic [31:0] ND [4] = '{32'habcd, 32'h1234, 32'h56, 32'h78};
  localparam logic [31:0] NE [4] = '{32'habcd2222, 32'habcd1234, 32'habcd5634, 32'habcd5678};
  logic          i_clk = 1'h0;
  logic          i_sys_rst, i_vec_load, i_exc_start, i_pc_we, i_sp_we, i_irq_req;
  logic          i_unmaskable_irq, o_aux_mask, o_irq_take, o_sel_bit;
  logic [23:0]   i_vec_pc, i_pc_d, i_mem_addr, o_pc, o_fetch_addr, o_mem_addr;
  logic [31:0]   i_sp_d, o_rd_data, o_sp;
  logic [2:0]    i_rd_idx, i_bit_sel;
  logic [7:0]    i_bit_byte, o_flags, o_bcd_adj;
  logic [3:0]    o_branch_flags;
  crf_gpr_wr_t   i_gpr_wr;
  crf_view_t     i_rd_view;
  crf_flag_req_t i_flag_req;
  crf_size_t     i_mem_size;
  int            n_fail = 0;
  int            n_compared = 0;
  always #20 i_clk = ~i_clk;
  crf_core crf_core_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_vec_load(i_vec_load),
    .i_vec_pc(i_vec_pc), .i_exc_start(i_exc_start), .i_pc_we(i_pc_we), .i_pc_d(i_pc_d),
    .i_gpr_wr(i_gpr_wr), .i_sp_we(i_sp_we), .i_sp_d(i_sp_d), .i_rd_idx(i_rd_idx),
    .i_rd_view(i_rd_view), .i_flag_req(i_flag_req), .i_bit_sel(i_bit_sel),
    .i_bit_byte(i_bit_byte), .i_mem_addr(i_mem_addr), .i_mem_size(i_mem_size),
    .i_irq_req(i_irq_req), .i_unmaskable_irq(i_unmaskable_irq), .o_rd_data(o_rd_data),
    .o_sp(o_sp), .o_pc(o_pc), .o_fetch_addr(o_fetch_addr), .o_mem_addr(o_mem_addr),
    .o_flags(o_flags), .o_branch_flags(o_branch_flags), .o_aux_mask(o_aux_mask),
    .o_irq_take(o_irq_take), .o_sel_bit(o_sel_bit), .o_bcd_adj(o_bcd_adj));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic step;
    @(posedge i_clk);
    @(negedge i_clk);
  endtask
  task automatic wr(input logic [2:0] x, input crf_view_t v, input logic [31:0] d);
    i_gpr_wr = '{1'h1, x, v, d};
    step();
  endtask
  task automatic rd(input logic [2:0] x, input crf_view_t v, input logic [31:0] e);
    i_rd_idx = x;
    i_rd_view = v;
    #1 chk("read", e, o_rd_data);
  endtask
  task automatic close_out;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    {i_sys_rst, i_vec_load, i_exc_start, i_pc_we, i_sp_we, i_irq_req} = 6'h20;
    {i_unmaskable_irq, i_vec_pc, i_pc_d, i_mem_addr, i_sp_d} = '0;
    {i_rd_idx, i_bit_sel, i_bit_byte, i_gpr_wr, i_flag_req} = '0;
    i_rd_view = VIEW_LONG;
    i_mem_size = SZ_BYTE;
    repeat (3) @(negedge i_clk);
    i_sys_rst = 1'h0;
    chk("reset mask", 32'h1, {31'h0, o_flags[FLG_IMASK]});
    // Stack pointer has no defined reset value, so it is loaded first
    wr(STACK_GPR_IDX, VIEW_LONG, 32'h00fffe00);
    i_gpr_wr.we = 1'h0;
    chk("sp init", 32'h00fffe00, o_sp);
    foreach (ROWS[k]) begin
      i_flag_req = '{ROWS[k].op, ROWS[k].sz, ROWS[k].a, ROWS[k].b, 1'h0, ROWS[k].res,
                     ROWS[k].imm[0], ROWS[k].imm[0], ROWS[k].imm};
      step();
      chk("flags", {24'h0, ROWS[k].exp}, {24'h0, o_flags & ROWS[k].msk});
    end
    i_flag_req = '0;
    i_irq_req = 1'h1;
    #1 chk("irq open", 32'h1, {31'h0, o_irq_take});
    // Exception entry lands with a same-cycle flag load; the mask must still win
    i_exc_start = 1'h1;
    i_flag_req.op = FOP_LOAD;
    step();
    {i_exc_start, i_flag_req} = '0;
    chk("exc mask", 32'h80, {24'h0, o_flags});
    chk("irq masked", 32'h0, {31'h0, o_irq_take});
    i_unmaskable_irq = 1'h1;
    #1 chk("nmi", 32'h1, {31'h0, o_irq_take});
    {i_irq_req, i_unmaskable_irq} = 2'h0;
    // Half-carry set so the subtract adjust has a digit to correct
    i_flag_req.op = FOP_LOAD;
    i_flag_req.imm = 8'ha0;
    step();
    chk("flag load", 32'ha0, {24'h0, o_flags});
    i_flag_req.op = FOP_DAA;
    i_flag_req.a = 32'h0a;
    #1 chk("bcd", 32'h10, {24'h0, o_bcd_adj});
    i_flag_req.op = FOP_DAS;
    i_flag_req.a = 32'h2d;
    #1 chk("bcd sub", 32'h27, {24'h0, o_bcd_adj});
    i_flag_req = '0;
    for (int k = 0; k < 8; k++) wr(k[2:0], VIEW_LONG, 32'h11111111 * k);
    for (int k = 0; k < 8; k++) rd(k[2:0], VIEW_LONG, 32'h11111111 * k);
    for (int k = 0; k < 4; k++) begin
      wr(3'h2, NV[k], ND[k]);
      rd(3'h2, VIEW_LONG, NE[k]);
      rd(3'h2, NV[k], ND[k]);
    end
    i_sp_we = 1'h1;
    i_sp_d = 32'hcafe0000;
    wr(3'h7, VIEW_LONG, 32'h0);
    {i_sp_we, i_gpr_wr.we} = 2'h0;
    chk("sp", 32'hcafe0000, o_sp);
    rd(3'h7, VIEW_LONG, 32'hcafe0000);
    {i_vec_load, i_pc_we, i_vec_pc} = {2'h3, 24'h123457};
    step();
    i_vec_load = 1'h0;
    i_pc_d = 24'h000101;
    chk("pc", 32'h123457, {8'h0, o_pc});
    chk("fetch", 32'h123456, {8'h0, o_fetch_addr});
    step();
    i_pc_we = 1'h0;
    chk("pc write", 32'h101, {8'h0, o_pc});
    chk("fetch odd", 32'h100, {8'h0, o_fetch_addr});
    i_mem_addr = 24'h000fff;
    for (int k = 0; k < 3; k++) begin
      i_mem_size = crf_size_t'(k);
      #1 chk("mem", (k == 0) ? 32'hfff : 32'hffe, {8'h0, o_mem_addr});
    end
    // Stack traffic uses longword size at an odd address
    i_mem_addr = 24'hfe0001;
    #1 chk("stack addr", 32'hfe0000, {8'h0, o_mem_addr});
    for (int k = 0; k < 8; k++) begin
      i_bit_sel = k[2:0];
      i_bit_byte = 8'h01 << k;
      #1 chk("bit", 32'h1, {31'h0, o_sel_bit});
      i_bit_byte = ~i_bit_byte;
      #1 chk("bit", 32'h0, {31'h0, o_sel_bit});
    end
    @(negedge i_clk);
    i_sys_rst = 1'h1;
    step();
    i_sys_rst = 1'h0;
    chk("rerun mask", 32'h1, {31'h0, o_flags[FLG_IMASK]});
    chk("rerun pc", {8'h0, PC_RST}, {8'h0, o_pc});
    close_out();
  end
  // Cuts a hang short; counted as a mismatch
  initial begin
    repeat (5000) @(posedge i_clk);
    n_fail++;
    close_out();
  end
endmodule
`default_nettype wire
